// ### pkg/cmrb_regs.vh
// Constants for the move, rotate and branch decoder: opcodes, timing and spaces.
// Assumes inclusion by bare name from rtl files; holds definitions only.
//
// Behaviour
// [RULE1] At most three bytes, ten base cycles
// [RULE2] Wait states only stretch ROM/external accesses
// [RULE3] Per-opcode extra cycles added per wait state
// [RULE4] Indirect pointer via 8-bit operand, even address
// [RULE5] Target low at pointer, high at pointer+1; indirect jump 2A takes high at pointer, low at pointer+1
// [RULE6] Register copies leave carry, sign, zero alone
// [RULE7] Opcodes 10-13 register copies, three bytes
// [RULE8] Code load 7 cycles, store 8, plus 4
// [RULE9] Data-space adds four waits when both bits set
// [RULE10] Pop pre-increments pointer, 10 cycles plus 3
// [RULE11] Push post-decrements pointer, 9 cycles plus 3
// [RULE12] Tech RAM read 1A, write 1B, 7 cycles
// [RULE13] Pair copy 1C moves 16 bits, 7 cycles
// [RULE14] Rotates: register only, carry only, 2 bytes
// [RULE15] 30-33 rotates, plain and through carry
// [RULE16] 34-36 shifts: zero fill or sign duplicate
// [RULE17] Absolute targets low-high; jump, call, returns
// [RULE18] 20/21 jump on carry set/clear
// [RULE19] 22/23 jump on zero set/clear
// [RULE20] 24/25 jump on sign set/clear
// [RULE21] Indirect jump 2A via even pointer, 4 cycles
// [RULE22] Opcode fetched first, then operands in order
`ifndef CMRB_REGS_VH
`define CMRB_REGS_VH

// ==========================================================================
// Opcodes
`define CMRB_OP_REG_RR 8'h10
`define CMRB_OP_REG_RI 8'h11
`define CMRB_OP_REG_IR 8'h12
`define CMRB_OP_REG_IMM 8'h13
`define CMRB_OP_CODE_LD 8'h14
`define CMRB_OP_CODE_ST 8'h15
`define CMRB_OP_DATA_RD 8'h16
`define CMRB_OP_DATA_WR 8'h17
`define CMRB_OP_POP 8'h18
`define CMRB_OP_PUSH 8'h19
`define CMRB_OP_TECH_RD 8'h1a
`define CMRB_OP_TECH_WR 8'h1b
`define CMRB_OP_PAIR 8'h1c
`define CMRB_OP_BR_C 8'h20
`define CMRB_OP_BR_NC 8'h21
`define CMRB_OP_BR_Z 8'h22
`define CMRB_OP_BR_NZ 8'h23
`define CMRB_OP_BR_S 8'h24
`define CMRB_OP_BR_NS 8'h25
`define CMRB_OP_JUMP 8'h26
`define CMRB_OP_CALL 8'h27
`define CMRB_OP_SUB_EXIT 8'h28
`define CMRB_OP_IRQ_EXIT 8'h29
`define CMRB_OP_IND_JUMP 8'h2a
`define CMRB_OP_ROL 8'h30
`define CMRB_OP_ROR 8'h31
`define CMRB_OP_ROLC 8'h32
`define CMRB_OP_RORC 8'h33
`define CMRB_OP_SHL 8'h34
`define CMRB_OP_SHR 8'h35
`define CMRB_OP_ASR 8'h36

// ==========================================================================
// Memory spaces
`define CMRB_SPACE_CODE 2'h0
`define CMRB_SPACE_DATA 2'h1
`define CMRB_SPACE_TECH 2'h2

// ==========================================================================
// Timing
`define CMRB_MAX_BYTES 2'h3
`define CMRB_MAX_BASE_CYCLES 4'ha
`define CMRB_DATA_EXTRA_WS 4'h4
`define CMRB_FLAGS_ADDR 8'hff

`endif

// ### rtl/cmrb_cycle_calc.v
// Length and cycle count of one opcode, with wait-state stretching.
// Assumes a static opcode and configuration; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "cmrb_regs.vh"

module cmrb_cycle_calc (
	// Instruction
	input wire [7:0] opcode,
	// Configuration
	input wire [2:0] wait_states,
	input wire access_in_sram,
	input wire data_space_extra_waits,
	input wire ext_rw_select,
	// Results
	output reg [1:0] length,
	output reg [3:0] base_cycles,
	output reg [2:0] per_ws,
	output reg legal,
	output wire [7:0] total_cycles
);
	// ======================================================================
	// Per-opcode table
	always @* begin
		legal = 1'b1;
		length = `CMRB_MAX_BYTES;
		base_cycles = 4'h3;
		per_ws = 3'h3;
		case (opcode)
			`CMRB_OP_REG_RR, `CMRB_OP_REG_RI: base_cycles = 4'h5; // [RULE7]
			`CMRB_OP_REG_IR: base_cycles = 4'h6; // [RULE7]
			`CMRB_OP_REG_IMM: base_cycles = 4'h4; // [RULE7]
			`CMRB_OP_CODE_LD, `CMRB_OP_DATA_RD: begin
				base_cycles = 4'h7; // [RULE8] [RULE9]
				per_ws = 3'h4;
			end
			`CMRB_OP_CODE_ST, `CMRB_OP_DATA_WR: begin
				base_cycles = 4'h8; // [RULE8] [RULE9]
				per_ws = 3'h4;
			end
			`CMRB_OP_POP: base_cycles = `CMRB_MAX_BASE_CYCLES; // [RULE10]
			`CMRB_OP_PUSH: base_cycles = 4'h9; // [RULE11]
			`CMRB_OP_TECH_RD, `CMRB_OP_TECH_WR: base_cycles = 4'h7; // [RULE12]
			`CMRB_OP_PAIR: base_cycles = 4'h7; // [RULE13]
			`CMRB_OP_BR_C, `CMRB_OP_BR_NC, `CMRB_OP_BR_Z, `CMRB_OP_BR_NZ,
			`CMRB_OP_BR_S, `CMRB_OP_BR_NS, `CMRB_OP_JUMP, `CMRB_OP_CALL:
				base_cycles = 4'h3; // [RULE17] [RULE18] [RULE19] [RULE20]
			`CMRB_OP_SUB_EXIT, `CMRB_OP_IRQ_EXIT: begin
				length = 2'h1; // [RULE17]
				base_cycles = 4'h2;
				per_ws = 3'h1;
			end
			`CMRB_OP_IND_JUMP: begin
				length = 2'h2; // [RULE21]
				base_cycles = 4'h4;
				per_ws = 3'h2;
			end
			`CMRB_OP_ROL, `CMRB_OP_ROR, `CMRB_OP_ROLC, `CMRB_OP_RORC,
			`CMRB_OP_SHL, `CMRB_OP_SHR, `CMRB_OP_ASR: begin
				length = 2'h2; // [RULE14]
				base_cycles = 4'h5;
				per_ws = 3'h2;
			end
			default: begin
				legal = 1'b0;
				length = 2'h1;
				base_cycles = 4'h1;
				per_ws = 3'h0;
			end
		endcase
	end

	// ======================================================================
	// Wait-state stretching
	wire data_op;
	wire [3:0] ws_eff;
	wire [6:0] extra;
	assign data_op = (opcode == `CMRB_OP_DATA_RD) || (opcode == `CMRB_OP_DATA_WR);
	assign ws_eff = (access_in_sram ? 4'h0 : {1'b0, wait_states}) + // [RULE2]
		((data_op && data_space_extra_waits && ext_rw_select) ?
		`CMRB_DATA_EXTRA_WS : 4'h0); // [RULE9]
	assign extra = {4'h0, per_ws} * {3'h0, ws_eff}; // [RULE3]
	assign total_cycles = {4'h0, base_cycles} + {1'b0, extra}; // [RULE1]

endmodule
`default_nettype wire

// ### rtl/cmrb_decode.v
// Move, rotate/shift and branch decoder and sequencer of the core.
// Assumes program bytes in order, register space with combinational read
// of a registered address, memory read data valid while the enable stands.
`timescale 1ns/100ps
`default_nettype none
`include "cmrb_regs.vh"

module cmrb_decode (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Program bytes
	input wire byte_valid,
	input wire [7:0] byte_data,
	output reg byte_ready,
	// Configuration
	input wire [2:0] wait_states,
	input wire access_in_sram,
	input wire data_space_extra_waits,
	input wire ext_rw_select,
	// Flags
	input wire carry_in,
	input wire zero_in,
	input wire sign_in,
	output reg carry_wr_en,
	output reg carry_wr_data,
	// Register space
	output reg [7:0] reg_rd_addr,
	input wire [7:0] reg_rd_data,
	output reg reg_wr_en,
	output reg [7:0] reg_wr_addr,
	output reg [7:0] reg_wr_data,
	// Memory spaces
	output reg mem_en,
	output reg mem_we,
	output reg [1:0] mem_space,
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	input wire [7:0] mem_rdata,
	// Program flow
	output reg pc_load,
	output reg [15:0] pc_target,
	output reg call_req,
	output reg sub_exit_req,
	output reg irq_exit_req,
	// Status
	output reg busy,
	output reg instr_done,
	output reg [7:0] instr_cycles,
	output reg illegal_op,
	output reg ptr_align_err
);
	// ======================================================================
	// States
	localparam [4:0] S_FETCH = 5'b00001;
	localparam [4:0] S_OP1 = 5'b00010;
	localparam [4:0] S_OP2 = 5'b00100;
	localparam [4:0] S_RUN = 5'b01000;
	localparam [4:0] S_HOLD = 5'b10000;

	reg [4:0] state_reg;
	reg [7:0] opcode_reg;
	reg [7:0] op1_reg;
	reg [7:0] op2_reg;
	reg [7:0] lo_reg;
	reg [7:0] hi_reg;
	reg [2:0] step_reg;
	reg [7:0] cyc_reg;

	// ======================================================================
	// Timing lookup
	wire [7:0] cur_op;
	wire [1:0] op_len;
	wire op_legal;
	wire [7:0] op_total;
	assign cur_op = (state_reg == S_FETCH) ? byte_data : opcode_reg;

	cmrb_cycle_calc u_calc (
		.opcode(cur_op),
		.wait_states(wait_states),
		.access_in_sram(access_in_sram),
		.data_space_extra_waits(data_space_extra_waits),
		.ext_rw_select(ext_rw_select),
		.length(op_len),
		.base_cycles(),
		.per_ws(),
		.legal(op_legal),
		.total_cycles(op_total)
	);

	// ======================================================================
	// Operand classes
	wire dest_ind;
	wire wide_ptr;
	wire cond_taken;
	wire [7:0] d;
	assign d = reg_rd_data;
	assign dest_ind = (opcode_reg == `CMRB_OP_REG_RI) || (opcode_reg == `CMRB_OP_CODE_ST) ||
		(opcode_reg == `CMRB_OP_DATA_WR) || (opcode_reg == `CMRB_OP_PUSH) ||
		(opcode_reg == `CMRB_OP_TECH_WR);
	assign wide_ptr = (opcode_reg == `CMRB_OP_CODE_LD) || (opcode_reg == `CMRB_OP_CODE_ST) ||
		(opcode_reg == `CMRB_OP_DATA_RD) || (opcode_reg == `CMRB_OP_DATA_WR) ||
		(opcode_reg == `CMRB_OP_TECH_RD) || (opcode_reg == `CMRB_OP_TECH_WR);
	assign cond_taken = (opcode_reg == `CMRB_OP_BR_C) ? carry_in : // [RULE18]
		(opcode_reg == `CMRB_OP_BR_NC) ? !carry_in : // [RULE18]
		(opcode_reg == `CMRB_OP_BR_Z) ? zero_in : // [RULE19]
		(opcode_reg == `CMRB_OP_BR_NZ) ? !zero_in : // [RULE19]
		(opcode_reg == `CMRB_OP_BR_S) ? sign_in : // [RULE20]
		(opcode_reg == `CMRB_OP_BR_NS) ? !sign_in : // [RULE20]
		1'b1;

	// ======================================================================
	// Rotate and shift unit
	reg [7:0] rot_val;
	reg rot_carry;
	always @* begin
		rot_val = d;
		rot_carry = carry_in;
		case (opcode_reg)
			`CMRB_OP_ROL: begin
				rot_val = {d[6:0], d[7]}; // [RULE15]
				rot_carry = d[7];
			end
			`CMRB_OP_ROR: begin
				rot_val = {d[0], d[7:1]}; // [RULE15]
				rot_carry = d[0];
			end
			`CMRB_OP_ROLC: begin
				rot_val = {d[6:0], carry_in}; // [RULE15]
				rot_carry = d[7];
			end
			`CMRB_OP_RORC: begin
				rot_val = {carry_in, d[7:1]}; // [RULE15]
				rot_carry = d[0];
			end
			`CMRB_OP_SHL: begin
				rot_val = {d[6:0], 1'b0}; // [RULE16]
				rot_carry = d[7];
			end
			`CMRB_OP_SHR: begin
				rot_val = {1'b0, d[7:1]}; // [RULE16]
				rot_carry = d[0];
			end
			`CMRB_OP_ASR: begin
				rot_val = {d[7], d[7:1]}; // [RULE16]
				rot_carry = d[0];
			end
			default: begin
				rot_val = d;
				rot_carry = carry_in;
			end
		endcase
	end

	// ======================================================================
	// Space of the indirect memory transfer
	reg [1:0] space_sel;
	always @* begin
		if (opcode_reg == `CMRB_OP_DATA_RD || opcode_reg == `CMRB_OP_DATA_WR) begin
			space_sel = `CMRB_SPACE_DATA;
		end else if (opcode_reg == `CMRB_OP_TECH_RD || opcode_reg == `CMRB_OP_TECH_WR) begin
			space_sel = `CMRB_SPACE_TECH;
		end else begin
			space_sel = `CMRB_SPACE_CODE;
		end
	end

	// ======================================================================
	// Sequencer
	reg finish;
	always @* begin
		finish = 1'b0;
		if (state_reg == S_RUN) begin
			case (opcode_reg)
				`CMRB_OP_REG_RR, `CMRB_OP_REG_IMM, `CMRB_OP_SUB_EXIT,
				`CMRB_OP_IRQ_EXIT: finish = 1'b1;
				`CMRB_OP_REG_RI, `CMRB_OP_REG_IR, `CMRB_OP_POP, `CMRB_OP_PAIR,
				`CMRB_OP_IND_JUMP: finish = (step_reg == 3'h1);
				`CMRB_OP_ROL, `CMRB_OP_ROR, `CMRB_OP_ROLC, `CMRB_OP_RORC,
				`CMRB_OP_SHL, `CMRB_OP_SHR, `CMRB_OP_ASR: finish = 1'b1;
				default: finish = (step_reg == 3'h2);
			endcase
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= S_FETCH;
			opcode_reg <= 8'h00;
			op1_reg <= 8'h00;
			op2_reg <= 8'h00;
			lo_reg <= 8'h00;
			hi_reg <= 8'h00;
			step_reg <= 3'h0;
			cyc_reg <= 8'h00;
			byte_ready <= 1'b1;
			carry_wr_en <= 1'b0;
			carry_wr_data <= 1'b0;
			reg_rd_addr <= 8'h00;
			reg_wr_en <= 1'b0;
			reg_wr_addr <= 8'h00;
			reg_wr_data <= 8'h00;
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			mem_space <= `CMRB_SPACE_CODE;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			pc_load <= 1'b0;
			pc_target <= 16'h0000;
			call_req <= 1'b0;
			sub_exit_req <= 1'b0;
			irq_exit_req <= 1'b0;
			busy <= 1'b0;
			instr_done <= 1'b0;
			instr_cycles <= 8'h00;
			illegal_op <= 1'b0;
			ptr_align_err <= 1'b0;
		end else begin
			carry_wr_en <= 1'b0;
			reg_wr_en <= 1'b0;
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			pc_load <= 1'b0;
			call_req <= 1'b0;
			sub_exit_req <= 1'b0;
			irq_exit_req <= 1'b0;
			instr_done <= 1'b0;
			if (state_reg != S_FETCH) begin
				cyc_reg <= cyc_reg + 8'h01;
			end
			case (state_reg)
				S_FETCH: begin
					if (byte_valid) begin
						opcode_reg <= byte_data; // [RULE22]
						cyc_reg <= 8'h02;
						step_reg <= 3'h0;
						illegal_op <= !op_legal;
						ptr_align_err <= 1'b0;
						busy <= 1'b1;
						if (!op_legal) begin
							state_reg <= S_FETCH;
							instr_done <= 1'b1;
							instr_cycles <= 8'h01;
							busy <= 1'b0;
						end else if (op_len == 2'h1) begin
							state_reg <= S_RUN;
							byte_ready <= 1'b0;
						end else begin
							state_reg <= S_OP1;
						end
					end
				end
				S_OP1: begin
					if (byte_valid) begin
						op1_reg <= byte_data; // [RULE22]
						if (op_len == 2'h2) begin
							state_reg <= S_RUN;
							byte_ready <= 1'b0;
							if (opcode_reg == `CMRB_OP_IND_JUMP) begin
								reg_rd_addr <= byte_data + 8'h01;
								ptr_align_err <= byte_data[0]; // [RULE21]
							end else begin
								reg_rd_addr <= byte_data; // [RULE14]
							end
						end else begin
							state_reg <= S_OP2;
						end
					end
				end
				S_OP2: begin
					if (byte_valid) begin
						op2_reg <= byte_data; // [RULE22]
						reg_rd_addr <= dest_ind ? op1_reg : byte_data; // [RULE4]
						if (wide_ptr) begin
							ptr_align_err <= dest_ind ? op1_reg[0] : byte_data[0]; // [RULE4]
						end
						if (opcode_reg[7:4] == 4'h2) begin
							if (cond_taken) begin
								pc_load <= 1'b1; // [RULE17]
								pc_target <= {byte_data, op1_reg}; // [RULE17]
							end
							call_req <= (opcode_reg == `CMRB_OP_CALL); // [RULE17]
							byte_ready <= (cyc_reg >= op_total);
							busy <= (cyc_reg < op_total);
							instr_done <= (cyc_reg >= op_total);
							instr_cycles <= cyc_reg;
							state_reg <= (cyc_reg >= op_total) ? S_FETCH : S_HOLD;
						end else begin
							byte_ready <= 1'b0;
							state_reg <= S_RUN;
						end
					end
				end
				S_RUN: begin
					step_reg <= step_reg + 3'h1;
					case (opcode_reg)
						`CMRB_OP_REG_RR: begin
							reg_wr_en <= 1'b1; // [RULE6] [RULE7]
							reg_wr_addr <= op1_reg;
							reg_wr_data <= d;
						end
						`CMRB_OP_REG_IMM: begin
							reg_wr_en <= 1'b1; // [RULE7]
							reg_wr_addr <= op1_reg;
							reg_wr_data <= op2_reg;
						end
						`CMRB_OP_REG_RI: begin
							if (step_reg == 3'h0) begin
								lo_reg <= d;
								reg_rd_addr <= op2_reg;
							end else begin
								reg_wr_en <= 1'b1; // [RULE7]
								reg_wr_addr <= lo_reg;
								reg_wr_data <= d;
							end
						end
						`CMRB_OP_REG_IR: begin
							if (step_reg == 3'h0) begin
								reg_rd_addr <= d;
							end else begin
								reg_wr_en <= 1'b1; // [RULE7]
								reg_wr_addr <= op1_reg;
								reg_wr_data <= d;
							end
						end
						`CMRB_OP_CODE_LD, `CMRB_OP_DATA_RD, `CMRB_OP_TECH_RD: begin
							if (step_reg == 3'h0) begin
								lo_reg <= d; // [RULE5]
								reg_rd_addr <= op2_reg + 8'h01;
							end else if (step_reg == 3'h1) begin
								mem_en <= 1'b1; // [RULE8] [RULE9] [RULE12]
								mem_space <= space_sel;
								mem_addr <= {d, lo_reg}; // [RULE5]
							end else begin
								reg_wr_en <= 1'b1;
								reg_wr_addr <= op1_reg;
								reg_wr_data <= mem_rdata;
							end
						end
						`CMRB_OP_CODE_ST, `CMRB_OP_DATA_WR, `CMRB_OP_TECH_WR: begin
							if (step_reg == 3'h0) begin
								lo_reg <= d; // [RULE5]
								reg_rd_addr <= op1_reg + 8'h01;
							end else if (step_reg == 3'h1) begin
								hi_reg <= d; // [RULE5]
								reg_rd_addr <= op2_reg;
							end else begin
								mem_en <= 1'b1; // [RULE8] [RULE9] [RULE12]
								mem_we <= 1'b1;
								mem_space <= space_sel;
								mem_addr <= {hi_reg, lo_reg};
								mem_wdata <= d;
							end
						end
						`CMRB_OP_POP: begin
							if (step_reg == 3'h0) begin
								reg_wr_en <= 1'b1; // [RULE10]
								reg_wr_addr <= op2_reg;
								reg_wr_data <= d + 8'h01;
								reg_rd_addr <= d + 8'h01;
							end else begin
								reg_wr_en <= 1'b1; // [RULE10]
								reg_wr_addr <= op1_reg;
								reg_wr_data <= d;
							end
						end
						`CMRB_OP_PUSH: begin
							if (step_reg == 3'h0) begin
								lo_reg <= d;
								reg_rd_addr <= op2_reg;
							end else if (step_reg == 3'h1) begin
								reg_wr_en <= 1'b1; // [RULE11]
								reg_wr_addr <= lo_reg;
								reg_wr_data <= d;
							end else begin
								reg_wr_en <= 1'b1; // [RULE11]
								reg_wr_addr <= op1_reg;
								reg_wr_data <= lo_reg - 8'h01;
							end
						end
						`CMRB_OP_PAIR: begin
							reg_wr_en <= 1'b1; // [RULE13]
							reg_wr_data <= d;
							if (step_reg == 3'h0) begin
								reg_wr_addr <= op1_reg;
								reg_rd_addr <= op2_reg + 8'h01;
							end else begin
								reg_wr_addr <= op1_reg + 8'h01;
							end
						end
						`CMRB_OP_IND_JUMP: begin
							if (step_reg == 3'h0) begin
								lo_reg <= d; // [RULE21]
								reg_rd_addr <= op1_reg;
							end else begin
								pc_load <= 1'b1; // [RULE21]
								pc_target <= {d, lo_reg};
							end
						end
						`CMRB_OP_SUB_EXIT: sub_exit_req <= 1'b1; // [RULE17]
						`CMRB_OP_IRQ_EXIT: irq_exit_req <= 1'b1; // [RULE17]
						default: begin
							reg_wr_en <= 1'b1; // [RULE14]
							reg_wr_addr <= op1_reg;
							reg_wr_data <= rot_val;
							carry_wr_en <= 1'b1; // [RULE14]
							carry_wr_data <= rot_carry;
						end
					endcase
					if (finish) begin
						byte_ready <= (cyc_reg >= op_total);
						busy <= (cyc_reg < op_total);
						instr_done <= (cyc_reg >= op_total);
						instr_cycles <= cyc_reg;
						state_reg <= (cyc_reg >= op_total) ? S_FETCH : S_HOLD;
					end
				end
				S_HOLD: begin
					if (cyc_reg >= op_total) begin
						state_reg <= S_FETCH; // [RULE3]
						byte_ready <= 1'b1;
						busy <= 1'b0;
						instr_done <= 1'b1;
						instr_cycles <= cyc_reg;
					end
				end
				default: state_reg <= S_FETCH;
			endcase
		end
	end

endmodule
`default_nettype wire

// ### verification/cmrb_decode_sva.sv
// Checker for the move, rotate and branch decoder.
// Assumes a bind to cmrb_decode; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cmrb_decode_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration and handshake
	input wire logic byte_ready,
	input wire logic access_in_sram,
	input wire logic data_space_extra_waits,
	// Watched outputs
	input wire logic carry_wr_en,
	input wire logic reg_wr_en,
	input wire logic pc_load,
	input wire logic sub_exit_req,
	input wire logic busy,
	input wire logic instr_done,
	input wire logic [7:0] instr_cycles
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
// ==========================================================================
// Properties
property p_max_base;
	instr_done && access_in_sram && !data_space_extra_waits |-> instr_cycles <= 8'ha;
endproperty
a_max_base: assert property (p_max_base) else $error("base cycles above ten");
property p_bounded;
	$rose(busy) |-> ##[1:60] instr_done;
endproperty
a_bounded: assert property (p_bounded) else $error("instruction never completed");
property p_done_idle;
	instr_done |-> !busy && byte_ready;
endproperty
a_done_idle: assert property (p_done_idle) else $error("not idle at completion");
property p_write_busy;
	reg_wr_en |-> $past(busy);
endproperty
a_write_busy: assert property (p_write_busy) else $error("write outside instruction");
property p_pc_done;
	pc_load && access_in_sram |-> instr_done;
endproperty
a_pc_done: assert property (p_pc_done) else $error("branch load not at completion");
property p_pc_once;
	pc_load |=> !pc_load;
endproperty
a_pc_once: assert property (p_pc_once) else $error("branch load longer than a pulse");
property p_exit_time;
	sub_exit_req && access_in_sram |-> instr_done && instr_cycles == 8'h2;
endproperty
a_exit_time: assert property (p_exit_time) else $error("return not two cycles");
property p_rot_write;
	carry_wr_en |-> reg_wr_en;
endproperty
a_rot_write: assert property (p_rot_write) else $error("carry without register write");
property p_rot_time;
	carry_wr_en && access_in_sram |-> ##1 !instr_done ##1 instr_done;
endproperty
a_rot_time: assert property (p_rot_time) else $error("rotate not five cycles");
c_jump: cover property (pc_load);
c_rot: cover property (carry_wr_en);
c_exit: cover property (sub_exit_req);
endmodule
bind cmrb_decode cmrb_decode_sva cmrb_decode_sva_inst (.clk(clk), .rstn(rstn),
	.byte_ready(byte_ready), .access_in_sram(access_in_sram),
	.data_space_extra_waits(data_space_extra_waits), .carry_wr_en(carry_wr_en),
	.reg_wr_en(reg_wr_en), .pc_load(pc_load), .sub_exit_req(sub_exit_req), .busy(busy),
	.instr_done(instr_done), .instr_cycles(instr_cycles));
`default_nettype wire

// ### verification/test_cmrb_decode.sv
// Testbench for the move, rotate and branch decoder.
// Assumes register space read combinationally, memory read data combinational from the address.
`timescale 1ns/100ps
`default_nettype none
`include "cmrb_regs.vh"
module test_cmrb_decode;
logic clk = 0, rstn = 0, bv = 0, sram = 1, dxw = 0, rws = 0, cin = 0, zin = 0, sin = 0;
logic [7:0] bd = 0, mrd, rra, rwa, rwd, mwd, icyc, op;
logic [10:0] cap_wd;
logic [2:0] ws = 0, req;
logic brdy, cwe, cwd, rwe, men, mwe, pcl, callq, subq, irqq, busy, done, ill, align;
logic [1:0] msp;
logic [15:0] ma, pct, cap_pc, cap_ma;
logic [7:0] regs [0:255];
logic seen_pc, seen_c, cap_c, f;
logic [15:0] tab [0:17] = '{16'h1053, 16'h1153, 16'h1263, 16'h1343, 16'h1474, 16'h1584,
	16'h1674, 16'h1784, 16'h18a3, 16'h1993, 16'h1a73, 16'h1b73, 16'h1c73, 16'h2633,
	16'h2821, 16'h2921, 16'h2a42, 16'h3052};
int n_fail = 0, n_checks = 0, cyc = 0, k, i, j, nb;
cmrb_decode cmrb_decode_inst (.clk(clk), .rstn(rstn), .byte_valid(bv), .byte_data(bd),
	.byte_ready(brdy), .wait_states(ws), .access_in_sram(sram),
	.data_space_extra_waits(dxw), .ext_rw_select(rws), .carry_in(cin), .zero_in(zin),
	.sign_in(sin), .carry_wr_en(cwe), .carry_wr_data(cwd), .reg_rd_addr(rra),
	.reg_rd_data(regs[rra]), .reg_wr_en(rwe), .reg_wr_addr(rwa), .reg_wr_data(rwd),
	.mem_en(men), .mem_we(mwe), .mem_space(msp), .mem_addr(ma), .mem_wdata(mwd),
	.mem_rdata(mrd), .pc_load(pcl), .pc_target(pct), .call_req(callq),
	.sub_exit_req(subq), .irq_exit_req(irqq), .busy(busy), .instr_done(done),
	.instr_cycles(icyc), .illegal_op(ill), .ptr_align_err(align));
initial begin
	forever #5 clk = ~clk;
end
// ==========================================================================
// Register space, memory and pulse capture
assign mrd = ma[7:0] ^ 8'ha5;
always @(posedge clk) begin
	if (men) {cap_wd, cap_ma} <= {mwe, msp, mwd, ma};
	if (rwe) regs[rwa] <= rwd;
	if (pcl) begin
		seen_pc <= 1;
		cap_pc <= pct;
	end
	if (cwe) begin
		seen_c <= 1;
		cap_c <= cwd;
	end
	if (callq || subq || irqq) req <= req | {callq, subq, irqq};
	cyc <= cyc + 1;
	if (cyc == 20000) begin
		n_fail++;
		conclude;
	end
end
// ==========================================================================
// Tasks
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_checks++;
	if (got !== exp) begin
		n_fail++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task run(input logic [7:0] o, a, b, input int n, input int exp);
	seen_pc = 0;
	seen_c = 0;
	req = 0;
	bv <= 1;
	bd <= o;
	@(posedge clk);
	if (n > 1) begin
		bd <= a;
		@(posedge clk);
	end
	if (n > 2) begin
		bd <= b;
		@(posedge clk);
	end
	bv <= 0;
	k = n - 1;
	do begin
		@(posedge clk);
		k++;
	end while (done !== 1'b1 && k < 80);
	chk(k[15:0], exp[15:0]);
	chk({8'h0, icyc}, exp[15:0]);
	@(posedge clk);
endtask
task conclude;
	$display("checks %0d mismatches %0d", n_checks, n_fail);
	if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
function logic [8:0] rot(input logic [2:0] s, input logic [7:0] v, input logic c);
	case (s)
	3'h0: rot = {v[7], v[6:0], v[7]};
	3'h1: rot = {v[0], v[0], v[7:1]};
	3'h2: rot = {v[7], v[6:0], c};
	3'h3: rot = {v[0], c, v[7:1]};
	3'h4: rot = {v[7], v[6:0], 1'b0};
	3'h5: rot = {v[0], 1'b0, v[7:1]};
	default: rot = {v[0], v[7], v[7:1]};
	endcase
endfunction
// ==========================================================================
// Tests
initial begin
	for (i = 0; i < 256; i++) regs[i] = i[7:0] ^ 8'h3c;
	repeat (4) @(posedge clk);
	rstn <= 1;
	@(posedge clk);
	run(8'h10, 8'h40, 8'h41, 3, 5);
	chk(regs[8'h40], 8'h7d);
	chk(seen_c, 0);
	sram <= 0;
	ws <= 3;
	run(8'h13, 8'h42, 8'h77, 3, 13);
	chk(regs[8'h42], 8'h77);
	ws <= 2;
	run(8'h14, 8'h50, 8'h20, 3, 15);
	chk(cap_ma, 16'h1d1c);
	chk(regs[8'h50], 8'hb9);
	chk(cap_wd[10:8], 3'h0);
	$display("test copy and code load done");
	sram <= 1;
	dxw <= 1;
	rws <= 1;
	run(8'h16, 8'h51, 8'h20, 3, 23);
	chk(cap_wd[10:8], 3'h1);
	rws <= 0;
	run(8'h16, 8'h51, 8'h20, 3, 7);
	dxw <= 0;
	$display("test data space waits done");
	run(8'h18, 8'h60, 8'h30, 3, 10);
	chk(regs[8'h30], 8'h0d);
	chk(regs[8'h60], 8'h31);
	run(8'h19, 8'h32, 8'h61, 3, 9);
	chk(regs[8'h0e], 8'h5d);
	chk(regs[8'h32], 8'h0d);
	run(8'h1c, 8'h70, 8'h72, 3, 7);
	chk({regs[8'h71], regs[8'h70]}, 16'h4f4e);
	run(8'h15, 8'h24, 8'h26, 3, 8);
	chk({cap_wd, cap_ma}, {11'h41a, 16'h1918});
	chk(align, 0);
	$display("test stack and pair done");
	run(8'h26, 8'h34, 8'h12, 3, 3);
	chk({seen_pc, cap_pc}, 17'h11234);
	run(8'h27, 8'h00, 8'h01, 3, 3);
	chk({req, seen_pc, cap_pc}, 20'h90100);
	run(8'h2a, 8'h44, 8'h00, 2, 4);
	chk({seen_pc, cap_pc}, 17'h17879);
	run(8'h2a, 8'h45, 8'h00, 2, 4);
	chk({align, seen_pc, cap_pc}, 18'h3797a);
	run(8'h28, 8'h00, 8'h00, 1, 2);
	chk(req, 3'h2);
	run(8'h29, 8'h00, 8'h00, 1, 2);
	chk(req, 3'h1);
	run(8'hff, 8'h00, 8'h00, 1, 1);
	chk(ill, 1);
	for (i = 0; i < 12; i++) begin
		op = 8'h20 + i[7:0] / 2;
		f = i[0];
		cin <= f;
		zin <= ~f;
		sin <= f;
		run(op, 8'h11, 8'h22, 3, 3);
		chk(seen_pc, (op[2:1] == 2'h1 ? !f : f) ^ op[0]);
	end
	$display("test branches done");
	for (i = 0; i < 14; i++) begin
		op = 8'h30 + i[7:0] / 2;
		cin <= i[0];
		regs[8'h52] = 8'h96;
		run(op, 8'h52, 8'h00, 2, 5);
		chk({seen_c, cap_c, regs[8'h52]}, {1'b1, rot(op[2:0], 8'h96, i[0])});
	end
	$display("test rotates done");
	for (j = 0; j < 2; j++) begin
		sram <= j[0];
		ws <= j[0] ? 3'h7 : 3'h2;
		for (i = 0; i < 18; i++) begin
			op = tab[i][15:8];
			nb = (op == 8'h28 || op == 8'h29) ? 1 : (op >= 8'h2a ? 2 : 3);
			run(op, 8'h20, 8'h22, nb, tab[i][7:4] + (j ? 0 : 2 * tab[i][3:0]));
		end
	end
	$display("test timing table done");
	conclude;
end
endmodule
`default_nettype wire
